//--- shared/vec_init_pkg.sv
// Constants for the interrupt vector builder and init sequencer
package vec_init_pkg;
  localparam logic [7:0] CALL_OPCODE = 8'hCD;
  localparam int INIT_SEL_BIT = 4;
  localparam int W1_LEVEL_BIT = 3;
  localparam int W1_SPACING_BIT = 2;
  localparam int W1_SINGLE_BIT = 1;
  localparam int W1_W4_BIT = 0;
  localparam int W4_PMODE_BIT = 0;
  localparam int W4_AUTO_EOS_BIT = 1;
  localparam int W4_MS_BIT = 2;
  localparam int W4_BUF_BIT = 3;
  localparam int W4_SFN_BIT = 4;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] WORD_RESET = 8'h00;
  localparam logic [2:0] SLAVE_ID_RESET = 3'h7;
  localparam logic [2:0] LOWEST_PRIO_RESET = 3'h7;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b000,
    SEQ_W2 = 3'b001,
    SEQ_W3 = 3'b010,
    SEQ_W4 = 3'b011,
    SEQ_READY = 3'b100
  } seq_state_t;

  typedef enum logic [1:0] {
    ACK_FIRST = 2'b00,
    ACK_SECOND = 2'b01,
    ACK_THIRD = 2'b10
  } ack_state_t;
endpackage

//--- src/vector_byte_gen.sv
// Vector byte builder for the acknowledge sequence
module vector_byte_gen
  import vec_init_pkg::*;
(
  input wire logic [1:0] ack_index,
  input wire logic processor_mode_bit,
  input wire logic routine_spacing_sel,
  input wire logic [7:0] word_one,
  input wire logic [7:0] word_two,
  input wire logic [2:0] level,
  output logic drive,
  output logic [7:0] byte_out
);
  always_comb begin
    drive = 1'b1;
    byte_out = 8'h00;
    if (processor_mode_bit) begin
      // Two-acknowledge: spacing and low address bits unused
      if (ack_index == 2'h0) begin
        drive = 1'b0;
      end else begin
        byte_out = {word_two[7:3], level};
      end
    end else begin
      unique case (ack_index)
        2'h0: byte_out = CALL_OPCODE;
        2'h1: begin
          if (routine_spacing_sel) begin
            byte_out = {word_one[7:5], level, 2'b00};
          end else begin
            byte_out = {word_one[7:6], level, 3'b000};
          end
        end
        default: byte_out = word_two;
      endcase
    end
  end
endmodule

//--- src/int_vector_init_seq.sv
// Init-word sequencer and acknowledge vector output
// Notes on behaviour
// - Three-ack mode: first ack drives CALL opcode byte.
// - Three-ack mode: second ack drives low routine address byte.
// - Spacing four: A7..A5, level in D4..D2, zeros below.
// - Spacing eight: A7..A6, level in D5..D3, zeros below.
// - Three-ack mode: third ack drives high address byte from word two.
// - Two-ack mode: no opcode; first ack freezes state, resolves priority.
// - Two-ack master puts slave identity on cascade at first ack end.
// - Two-ack mode: data bus floats during first ack.
// - Two-ack second ack: type bits T7..T3 plus level.
// - Two-ack mode ignores spacing bit and low address bits.
// - Write with D4 high and select low is word one, restarts.
// - Sequence: word one, two, three if not single, four if needed.
// - Word one resets edge detection; fresh rising edge needed.
// - Word one clears the interrupt mask.
// - Word one restores fixed priority, input 7 lowest.
// - Word one sets stored slave identity to 7.
// - Word one clears special mask, status reads show request register.
// - Word four not needed: all word-four options cleared.
// - Master/slave bit only counts in buffered mode.
// - Operation words accepted only after initialization finishes.
// - Spacing bit set means four locations, clear means eight.
// - Level-trigger bit makes requests level-sensitive, edge circuit off.
// - Processor-mode bit: zero three-ack CALL, one two-ack vector.
module int_vector_init_seq
  import vec_init_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_strobe,
  input wire logic port_select_line,
  input wire logic [7:0] wr_data,
  input wire logic int_ack_strobe,
  input wire logic [2:0] level_in,
  input wire logic [7:0] request_input,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic [2:0] cascade_out,
  output logic cascade_oe,
  output logic init_done,
  output logic operation_word_stb,
  output logic [7:0] operation_word,
  output logic [7:0] request_register,
  output logic [7:0] mask_out,
  output logic [2:0] lowest_prio,
  output logic read_request_sel,
  output logic special_mask,
  output logic level_trigger_sel,
  output logic single_device_flag,
  output logic auto_end_of_service,
  output logic buffered_mode,
  output logic master_mode,
  output logic processor_mode_bit,
  output logic [2:0] slave_id,
  output logic ack_freeze
);
  // Synchronised pin inputs
  logic [1:0] wr_s1_q, wr_s1_d;
  logic [1:0] ack_s1_q, ack_s1_d;
  logic [7:0] req_s1_q, req_s1_d, req_s2_q, req_s2_d;
  logic wr_s2_q, wr_s2_d, wr_s3_q, wr_s3_d;
  logic ack_s2_q, ack_s2_d, ack_s3_q, ack_s3_d;
  logic [8:0] wbus_s1_q, wbus_s1_d, wbus_s2_q, wbus_s2_d;
  logic [2:0] lvl_s1_q, lvl_s1_d, lvl_s2_q, lvl_s2_d;

  seq_state_t seq_q, seq_d;
  ack_state_t ack_q, ack_d;
  logic [7:0] word_one_q, word_one_d;
  logic [7:0] word_two_q, word_two_d;
  logic [7:0] word_three_q, word_three_d;
  logic [7:0] word_four_q, word_four_d;
  logic [7:0] mask_q, mask_d;
  logic [7:0] pend_q, pend_d;
  logic [7:0] req_prev_q, req_prev_d;
  logic [2:0] prio_q, prio_d;
  logic [2:0] sid_q, sid_d;
  logic [2:0] lvl_q, lvl_d;
  logic rd_req_q, rd_req_d;
  logic done_q, done_d, ms_q, ms_d;
  logic smm_q, smm_d;
  logic [7:0] dout_q, dout_d;
  logic doe_q, doe_d;
  logic [2:0] cas_q, cas_d;
  logic cas_oe_q, cas_oe_d;
  logic ow_stb_q, ow_stb_d;
  logic [7:0] ow_q, ow_d;
  logic freeze_q, freeze_d;

  logic wr_rise, ack_fall, ack_rise, is_init;
  logic gen_drive;
  logic [7:0] gen_byte;
  logic buf_en, ms_eff;

  vector_byte_gen u_gen (
    .ack_index(ack_d),
    .processor_mode_bit(word_four_q[W4_PMODE_BIT]),
    .routine_spacing_sel(word_one_q[W1_SPACING_BIT]),
    .word_one(word_one_q),
    .word_two(word_two_q),
    .level(lvl_q),
    .drive(gen_drive),
    .byte_out(gen_byte)
  );

  // Synchroniser next values
  always_comb begin
    wr_s1_d = {wr_s1_q[0], wr_strobe};
    ack_s1_d = {ack_s1_q[0], int_ack_strobe};
    wr_s2_d = wr_s1_q[1];
    wr_s3_d = wr_s2_q;
    ack_s2_d = ack_s1_q[1];
    ack_s3_d = ack_s2_q;
    req_s1_d = request_input;
    req_s2_d = req_s1_q;
    wbus_s1_d = {port_select_line, wr_data};
    wbus_s2_d = wbus_s1_q;
    lvl_s1_d = level_in;
    lvl_s2_d = lvl_s1_q;
  end

  // Strobe edges use the second stage onward only
  assign wr_rise = wr_s2_q & ~wr_s3_q;
  assign ack_fall = ~ack_s2_q & ack_s3_q;
  assign ack_rise = ack_s2_q & ~ack_s3_q;
  assign is_init = wr_rise & ~wbus_s2_q[8] & wbus_s2_q[INIT_SEL_BIT];
  assign buf_en = word_four_q[W4_BUF_BIT];
  assign ms_eff = buf_en & word_four_q[W4_MS_BIT];

  // Init sequencer and control state
  always_comb begin
    seq_d = seq_q;
    word_one_d = word_one_q;
    word_two_d = word_two_q;
    word_three_d = word_three_q;
    word_four_d = word_four_q;
    mask_d = mask_q;
    prio_d = prio_q;
    sid_d = sid_q;
    rd_req_d = rd_req_q;
    smm_d = smm_q;
    ow_stb_d = 1'b0;
    ow_d = ow_q;
    if (is_init) begin
      word_one_d = wbus_s2_q[7:0];
      mask_d = MASK_RESET;
      prio_d = LOWEST_PRIO_RESET;
      sid_d = SLAVE_ID_RESET;
      smm_d = 1'b0;
      rd_req_d = 1'b1;
      word_four_d = WORD_RESET;
      seq_d = SEQ_W2;
    end else if (wr_rise) begin
      unique case (seq_q)
        SEQ_IDLE: ;
        SEQ_W2: begin
          word_two_d = wbus_s2_q[7:0];
          if (!word_one_q[W1_SINGLE_BIT]) begin
            seq_d = SEQ_W3;
          end else if (word_one_q[W1_W4_BIT]) begin
            seq_d = SEQ_W4;
          end else begin
            seq_d = SEQ_READY;
          end
        end
        SEQ_W3: begin
          word_three_d = wbus_s2_q[7:0];
          sid_d = wbus_s2_q[2:0];
          seq_d = word_one_q[W1_W4_BIT] ? SEQ_W4 : SEQ_READY;
        end
        SEQ_W4: begin
          word_four_d = wbus_s2_q[7:0];
          seq_d = SEQ_READY;
        end
        SEQ_READY: begin
          ow_stb_d = 1'b1;
          ow_d = wbus_s2_q[7:0];
          if (wbus_s2_q[8]) begin
            mask_d = wbus_s2_q[7:0];
          end
        end
        default: seq_d = SEQ_IDLE;
      endcase
    end
    done_d = (seq_d == SEQ_READY);
    ms_d = word_four_d[W4_BUF_BIT] & word_four_d[W4_MS_BIT];
  end

  // Request register: edge or level sensed, cleared by word one, edge memory set to all ones
  always_comb begin
    req_prev_d = is_init ? 8'hFF : req_s2_q;
    pend_d = pend_q;
    if (is_init) begin
      pend_d = 8'h00;
    end else if (word_one_q[W1_LEVEL_BIT]) begin
      pend_d = req_s2_q;
    end else begin
      pend_d = pend_q | (req_s2_q & ~req_prev_q);
    end
    if (ack_rise && ack_q == ACK_FIRST && word_four_q[W4_PMODE_BIT]) begin
      pend_d[lvl_q] = 1'b0;
    end
  end

  // Acknowledge sequence and vector bytes
  always_comb begin
    ack_d = ack_q;
    lvl_d = lvl_q;
    freeze_d = freeze_q;
    dout_d = dout_q;
    doe_d = doe_q;
    cas_d = cas_q;
    cas_oe_d = cas_oe_q;
    if (is_init) begin
      ack_d = ACK_FIRST;
      doe_d = 1'b0;
      cas_oe_d = 1'b0;
      freeze_d = 1'b0;
    end else if (ack_fall) begin
      if (ack_q == ACK_FIRST) begin
        lvl_d = lvl_s2_q;
        freeze_d = 1'b1;
      end
      dout_d = gen_byte;
      doe_d = gen_drive;
    end else if (ack_rise) begin
      doe_d = 1'b0;
      if (ack_q == ACK_FIRST) begin
        ack_d = ACK_SECOND;
        if (word_four_q[W4_PMODE_BIT] && ms_eff) begin
          cas_d = lvl_q;
          cas_oe_d = 1'b1;
        end
      end else if (ack_q == ACK_SECOND && !word_four_q[W4_PMODE_BIT]) begin
        ack_d = ACK_THIRD;
      end else begin
        ack_d = ACK_FIRST;
        freeze_d = 1'b0;
        cas_oe_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    wr_s1_q <= wr_s1_d;
    ack_s1_q <= ack_s1_d;
    req_s1_q <= req_s1_d;
    req_s2_q <= req_s2_d;
    wbus_s1_q <= wbus_s1_d;
    wbus_s2_q <= wbus_s2_d;
    lvl_s1_q <= lvl_s1_d;
    lvl_s2_q <= lvl_s2_d;
    if (!rst_n) begin
      wr_s2_q <= 1'b0;
      wr_s3_q <= 1'b0;
      ack_s2_q <= 1'b1;
      ack_s3_q <= 1'b1;
      seq_q <= SEQ_IDLE;
      ack_q <= ACK_FIRST;
      word_one_q <= WORD_RESET;
      word_two_q <= WORD_RESET;
      word_three_q <= WORD_RESET;
      word_four_q <= WORD_RESET;
      mask_q <= MASK_RESET;
      pend_q <= 8'h00;
      req_prev_q <= 8'hFF;
      prio_q <= LOWEST_PRIO_RESET;
      sid_q <= SLAVE_ID_RESET;
      lvl_q <= 3'h0;
      rd_req_q <= 1'b1;
      smm_q <= 1'b0;
      dout_q <= 8'h00;
      doe_q <= 1'b0;
      cas_q <= 3'h0;
      cas_oe_q <= 1'b0;
      ow_stb_q <= 1'b0;
      ow_q <= 8'h00;
      freeze_q <= 1'b0;
      done_q <= 1'b0;
      ms_q <= 1'b0;
    end else begin
      wr_s2_q <= wr_s2_d;
      wr_s3_q <= wr_s3_d;
      ack_s2_q <= ack_s2_d;
      ack_s3_q <= ack_s3_d;
      seq_q <= seq_d;
      ack_q <= ack_d;
      word_one_q <= word_one_d;
      word_two_q <= word_two_d;
      word_three_q <= word_three_d;
      word_four_q <= word_four_d;
      mask_q <= mask_d;
      pend_q <= pend_d;
      req_prev_q <= req_prev_d;
      prio_q <= prio_d;
      sid_q <= sid_d;
      lvl_q <= lvl_d;
      rd_req_q <= rd_req_d;
      smm_q <= smm_d;
      dout_q <= dout_d;
      doe_q <= doe_d;
      cas_q <= cas_d;
      cas_oe_q <= cas_oe_d;
      ow_stb_q <= ow_stb_d;
      ow_q <= ow_d;
      freeze_q <= freeze_d;
      done_q <= done_d;
      ms_q <= ms_d;
    end
  end

  assign data_out = dout_q;
  assign data_oe = doe_q;
  assign cascade_out = cas_q;
  assign cascade_oe = cas_oe_q;
  assign init_done = done_q;
  assign operation_word_stb = ow_stb_q;
  assign operation_word = ow_q;
  assign request_register = pend_q;
  assign mask_out = mask_q;
  assign lowest_prio = prio_q;
  assign read_request_sel = rd_req_q;
  assign special_mask = smm_q;
  assign level_trigger_sel = word_one_q[W1_LEVEL_BIT];
  assign single_device_flag = word_one_q[W1_SINGLE_BIT];
  assign auto_end_of_service = word_four_q[W4_AUTO_EOS_BIT];
  assign buffered_mode = word_four_q[W4_BUF_BIT];
  assign master_mode = ms_q;
  assign processor_mode_bit = word_four_q[W4_PMODE_BIT];
  assign slave_id = sid_q;
  assign ack_freeze = freeze_q;
endmodule

//--- verif/host_model.sv
// Host side model: write cycles and acknowledge pulses
module host_model (
  input wire logic clk,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  output logic wr_strobe,
  output logic port_select_line,
  output logic [7:0] wr_data,
  output logic int_ack_strobe,
  output logic [2:0] level_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    wr_strobe = 1'b0;
    port_select_line = 1'b1;
    wr_data = 8'hFF;
    int_ack_strobe = 1'b1;
    level_in = 3'h0;
  end
  // Strobe held four clocks high and low
  task automatic write(input logic sel, input logic [7:0] d);
    port_select_line <= sel;
    wr_data <= d;
    wr_strobe <= 1'b1;
    repeat (4) @(posedge clk);
    wr_strobe <= 1'b0;
    repeat (2) @(posedge clk);
    wr_data <= ~d;
    port_select_line <= ~sel;
    repeat (2) @(posedge clk);
  endtask
  task automatic ack(input logic [2:0] lvl, output logic oe, output logic [7:0] d);
    level_in <= lvl;
    int_ack_strobe <= 1'b0;
    repeat (6) @(posedge clk);
    oe = data_oe;
    d = data_out;
    int_ack_strobe <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
endmodule

//--- verif/vec_init_asserts.sv
// Port checker for the init sequencer and vector output
module vec_init_asserts
  import vec_init_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_strobe,
  input wire logic port_select_line,
  input wire logic [7:0] wr_data,
  input wire logic int_ack_strobe,
  input wire logic [2:0] level_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic init_done,
  input wire logic operation_word_stb,
  input wire logic [7:0] request_register,
  input wire logic [7:0] mask_out,
  input wire logic [2:0] lowest_prio,
  input wire logic read_request_sel,
  input wire logic special_mask,
  input wire logic level_trigger_sel,
  input wire logic auto_end_of_service,
  input wire logic buffered_mode,
  input wire logic master_mode,
  input wire logic processor_mode_bit,
  input wire logic [2:0] slave_id
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence word_one_s;
    $rose(wr_strobe) && !port_select_line && wr_data[INIT_SEL_BIT];
  endsequence
  sequence edge_one_s;
    word_one_s ##0 !wr_data[W1_LEVEL_BIT];
  endsequence
  sequence short_one_s;
    word_one_s ##0 !wr_data[W1_W4_BIT];
  endsequence
  mask_clear_a: assert property (word_one_s |-> ##5 mask_out == 8'h00)
    else $error("mask not cleared by word one");
  prio_restore_a: assert property (word_one_s |-> ##5 lowest_prio == 3'h7)
    else $error("lowest priority not 7 after word one");
  slave_seven_a: assert property (word_one_s |-> ##5 slave_id == 3'h7)
    else $error("slave identity not 7 after word one");
  status_sel_a: assert property (word_one_s |-> ##5 read_request_sel && !special_mask)
    else $error("status or special mask wrong after word one");
  init_restart_a: assert property (word_one_s |-> ##5 !init_done)
    else $error("word one did not restart init");
  edge_reset_a: assert property (edge_one_s |-> ##5 request_register == 8'h00)
    else $error("request register kept after word one");
  no_word_four_a: assert property (short_one_s |-> ##5 !processor_mode_bit
    && !auto_end_of_service && !buffered_mode) else $error("word four options kept");
  level_sel_a: assert property (word_one_s |-> ##5
    level_trigger_sel == $past(wr_data[W1_LEVEL_BIT], 5)) else $error("level select wrong");
  master_buf_a: assert property (master_mode |-> buffered_mode)
    else $error("master without buffered mode");
  op_after_init_a: assert property (operation_word_stb |-> init_done)
    else $error("operation word before init done");
  vec_level_a: assert property (data_oe && processor_mode_bit |-> data_out[2:0] == level_in)
    else $error("vector level bits wrong");
  oe_release_a: assert property (int_ack_strobe [*8] |-> !data_oe)
    else $error("data bus driven without acknowledge");
endmodule
bind int_vector_init_seq vec_init_asserts u_asserts (.clk, .rst_n, .wr_strobe,
  .port_select_line, .wr_data, .int_ack_strobe, .level_in, .data_out, .data_oe, .init_done,
  .operation_word_stb, .request_register, .mask_out, .lowest_prio, .read_request_sel,
  .special_mask, .level_trigger_sel, .auto_end_of_service, .buffered_mode, .master_mode,
  .processor_mode_bit, .slave_id);

//--- verif/interrupt_vector_and_init_sequencer_tb.sv
// Testbench for the vector builder and init sequencer
module interrupt_vector_and_init_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n, wr_strobe, port_select_line, int_ack_strobe, data_oe, init_done, ack_freeze;
  logic read_request_sel, special_mask, level_trigger_sel, single_device_flag, cascade_oe;
  logic auto_end_of_service, buffered_mode, master_mode, processor_mode_bit;
  logic [7:0] wr_data, request_input, data_out, request_register, mask_out, operation_word;
  logic [2:0] level_in, lowest_prio, slave_id, cascade_out;
  int error_cnt, total_checks, cycles;
  always #50 clk = ~clk;
  host_model host (.clk, .data_out, .data_oe, .wr_strobe, .port_select_line, .wr_data,
    .int_ack_strobe, .level_in);
  int_vector_init_seq DUT (.clk, .rst_n, .wr_strobe, .port_select_line, .wr_data,
    .int_ack_strobe, .level_in, .request_input, .data_out, .data_oe, .cascade_out,
    .cascade_oe, .init_done, .operation_word_stb(), .operation_word, .request_register,
    .mask_out, .lowest_prio, .read_request_sel, .special_mask, .level_trigger_sel,
    .single_device_flag, .auto_end_of_service, .buffered_mode, .master_mode,
    .processor_mode_bit, .slave_id, .ack_freeze);
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic ack_chk(input logic [2:0] lvl, input logic oe_exp, input logic [7:0] exp);
    logic oe;
    logic [7:0] d;
    host.ack(lvl, oe, d);
    check({7'h0, oe}, {7'h0, oe_exp});
    if (oe_exp) check(d, exp);
  endtask
  task automatic t_call_mode(input logic sp);
    host.write(1'b0, {5'b10110, sp, 2'b10});
    check({7'h0, init_done}, 8'h00);
    host.write(1'b1, 8'h5A);
    check({4'h0, init_done, single_device_flag, processor_mode_bit, auto_end_of_service},
      8'h0C);
    for (int l = 0; l < 8; l++) begin
      ack_chk(3'(l), 1'b1, 8'hCD);
      ack_chk(3'(l), 1'b1, sp ? {3'b101, 3'(l), 2'b00} : {2'b10, 3'(l), 3'b000});
      ack_chk(3'(l), 1'b1, 8'h5A);
    end
  endtask
  task automatic t_vector_mode;
    host.write(1'b0, 8'hF5);
    host.write(1'b1, 8'hA5);
    host.write(1'b1, 8'h01);
    check({7'h0, init_done}, 8'h00);
    host.write(1'b1, 8'h05);
    check({5'h0, init_done, processor_mode_bit, master_mode}, 8'h06);
    for (int l = 0; l < 8; l++) begin
      ack_chk(3'(l), 1'b0, 8'h00);
      ack_chk(3'(l), 1'b1, {5'b10100, 3'(l)});
    end
    host.write(1'b1, 8'h3C);
    check(mask_out, 8'h3C);
    check(operation_word, 8'h3C);
  endtask
  task automatic t_reinit;
    request_input <= 8'h04;
    repeat (4) @(posedge clk);
    host.write(1'b0, 8'h13);
    check(mask_out, 8'h00);
    check({slave_id, lowest_prio, read_request_sel, special_mask}, 8'hFE);
    check(request_register, 8'h00);
    host.write(1'b1, 8'h00);
    host.write(1'b1, 8'h0D);
    check({6'h0, buffered_mode, master_mode}, 8'h03);
    ack_chk(3'h5, 1'b0, 8'h00);
    check({3'h0, ack_freeze, cascade_oe, cascade_out}, 8'h1D);
    ack_chk(3'h5, 1'b1, 8'h05);
    check({3'h0, ack_freeze, cascade_oe, cascade_out}, 8'h05);
    request_input <= 8'h00;
    repeat (4) @(posedge clk);
    request_input <= 8'h04;
    repeat (6) @(posedge clk);
    check(request_register, 8'h04);
    request_input <= 8'h00;
    host.write(1'b0, 8'h1A);
    check({4'h0, level_trigger_sel, init_done, buffered_mode, processor_mode_bit},
      8'h08);
    host.write(1'b1, 8'h00);
    check({7'h0, init_done}, 8'h01);
    request_input <= 8'h04;
    repeat (6) @(posedge clk);
    check(request_register, 8'h04);
    request_input <= 8'h00;
    repeat (6) @(posedge clk);
    check(request_register, 8'h00);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      print_verdict;
    end
  end
  initial begin
    rst_n = 1'b0;
    request_input = 8'h00;
    error_cnt = 0;
    total_checks = 0;
    cycles = 0;
    repeat (16) @(posedge clk);
    check(mask_out, 8'h00);
    check({slave_id, lowest_prio, read_request_sel, init_done}, 8'hFE);
    rst_n <= 1'b1;
    @(posedge clk);
    t_call_mode(1'b1);
    t_call_mode(1'b0);
    t_vector_mode;
    t_reinit;
    print_verdict;
  end
endmodule
